// ---- core/scio_top.v ----
// command-port logic of a servo drive: step counting, quadrature decode, encoder emulation
// assumes feedback position arrives on the core clock; pins are asynchronous
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scio_map.vh"
module scio_top
(
  // clock and reset
  input wire clk,
  input wire arst_n,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // drive state
  input wire powered,
  input wire faulted,
  input wire enabled,
  input wire hires_fb_present,
  input wire serial_fb_in_use,
  input wire [19:0] fb_position,
  input wire [3:0] resolution_rotary_switch,
  // command pins
  input wire step_pulse_input,
  input wire direction_input_pin,
  // channel a/b/z pins, oe low drives
  input wire chan_a_in,
  input wire chan_b_in,
  output reg chan_a_out,
  output reg chan_b_out,
  output reg chan_ab_oe_n,
  output reg marker_channel,
  output reg marker_oe_n,
  // status outputs
  output reg fault_status_output,
  output reg run_status_output,
  output reg [31:0] position_command
);
  // ==========================================
  // functions
  // both tables are pure decode, user_ppr for the switch mux and quad_step for the
  // clocked logic, so each process reads a plain value
  // user code to pulses per revolution
  function [15:0] user_ppr;
    input [3:0] code;
    begin
      case (code)
        4'h0: user_ppr = 16'd128;
        4'h1: user_ppr = 16'd512;
        4'h2: user_ppr = 16'd1024;
        4'h3: user_ppr = 16'd2048;
        4'h4: user_ppr = 16'd4096;
        4'h5: user_ppr = 16'd8192;
        4'h6: user_ppr = 16'd16384;
        4'h7: user_ppr = 16'd32768;
        4'h8: user_ppr = 16'd125;
        4'h9: user_ppr = 16'd500;
        4'ha: user_ppr = 16'd1000;
        4'hb: user_ppr = 16'd2000;
        4'hc: user_ppr = 16'd2500;
        4'hd: user_ppr = 16'd5000;
        4'he: user_ppr = 16'd10000;
        default: user_ppr = 16'd20000;
      endcase
    end
  endfunction
  // quadrature step direction: +1, -1 or 0 from old and new states
  // 01 means one count up, 11 one count down, 00 no move or an
  // illegal double step; a double step is dropped rather than guessed
  function [1:0] quad_step;
    input [1:0] prev;
    input [1:0] cur;
    begin
      case ({prev, cur})
        4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b01;
        4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b11;
        default: quad_step = 2'b00;
      endcase
    end
  endfunction
  // ==========================================
  // synchronised pins
  // every command pin is asynchronous to the core clock; the three
  // stage filter costs about four cycles of latency, far below the
  // shortest legal step pulse, so no step is lost
  wire step_s;
  wire dir_s;
  wire qa_s;
  wire qb_s;
  scio_sync u_sync_step (.clk(clk), .arst_n(arst_n), .din(step_pulse_input), .dout(step_s));
  scio_sync u_sync_dir (.clk(clk), .arst_n(arst_n), .din(direction_input_pin), .dout(dir_s));
  scio_sync u_sync_qa (.clk(clk), .arst_n(arst_n), .din(chan_a_in), .dout(qa_s));
  scio_sync u_sync_qb (.clk(clk), .arst_n(arst_n), .din(chan_b_in), .dout(qb_s));
  // ==========================================
  // registers
  // the mode bits are decoded once here so every process below sees
  // the same view of the command source in the same cycle
  reg [31:0] ctrl_reg; // mode bits
  reg [3:0] user_ppr_reg; // index of stored resolution
  reg [15:0] gear_num_reg;
  reg [15:0] gear_den_reg;
  reg [31:0] step_cnt_reg; // step/direction count
  reg [31:0] quad_cnt_reg; // decoded a/b count
  reg step_d_reg;
  reg [1:0] quad_d_reg;
  wire pos_mode = ctrl_reg[`SCIO_CTRL_POS_MODE];
  wire src_quad = ctrl_reg[`SCIO_CTRL_SRC_QUAD];
  // ==========================================
  // register writes
  // writes land at the strobe edge; unmapped and read-only offsets
  // are ignored so software probing does no harm
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg <= `SCIO_CTRL_RESET;
      user_ppr_reg <= `SCIO_USER_PPR_RESET;
      gear_num_reg <= `SCIO_GEAR_RESET;
      gear_den_reg <= `SCIO_GEAR_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SCIO_REG_CTRL: ctrl_reg <= {30'h0, reg_wdata[1:0]};
        `SCIO_REG_USER_PPR: user_ppr_reg <= reg_wdata[3:0];
        `SCIO_REG_GEAR_NUM: gear_num_reg <= reg_wdata[15:0];
        // zero denominator is held at one to keep the divide defined
        `SCIO_REG_GEAR_DEN: gear_den_reg <= (reg_wdata[15:0] == 16'h0) ? 16'h0001 : reg_wdata[15:0];
        default: ;
      endcase
    end
  end
  // ==========================================
  // register reads, unmapped read zero
  // data stands for exactly one cycle after the strobe and is zero
  // otherwise, so an or of several blocks needs no extra select
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SCIO_REG_CTRL: reg_rdata <= ctrl_reg;
        `SCIO_REG_STAT: reg_rdata <= {27'h0, serial_fb_in_use, hires_fb_present, run_status_output,
                                      fault_status_output, chan_ab_oe_n};
        `SCIO_REG_USER_PPR: reg_rdata <= {28'h0, user_ppr_reg};
        `SCIO_REG_GEAR_NUM: reg_rdata <= {16'h0, gear_num_reg};
        `SCIO_REG_GEAR_DEN: reg_rdata <= {16'h0, gear_den_reg};
        `SCIO_REG_POS_CMD: reg_rdata <= position_command;
        `SCIO_REG_QUAD_CNT: reg_rdata <= quad_cnt_reg;
        default: reg_rdata <= 32'h0;
      endcase
    end
    else
      reg_rdata <= 32'h0;
  end
  // ==========================================
  // status outputs
  // one register stage on both outputs keeps them glitch free while
  // the drive state inputs settle
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_status_output <= 1'b0;
      run_status_output <= 1'b0;
    end
    else
    begin
      fault_status_output <= powered & ~faulted;
      run_status_output <= powered & ~faulted & enabled;
    end
  end
  // ==========================================
  // step/direction counting; high synced level means photodiode current
  // the counter wraps silently; software reads the low 32 bits and
  // must take differences itself over long moves
  // direction is sampled at the counting edge, so a late change of
  // the direction pin lands on the wrong step
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      step_d_reg <= 1'b0;
      step_cnt_reg <= 32'h0;
    end
    else
    begin
      step_d_reg <= step_s;
      // falling edge only: current stops; rising edge ignored
      if (pos_mode && !src_quad && step_d_reg && !step_s)
        step_cnt_reg <= dir_s ? step_cnt_reg - 32'h1 : step_cnt_reg + 32'h1;
    end
  end
  // ==========================================
  // quadrature decode, only while a/b are inputs
  // the pins stay filtered in output mode but the count holds, so
  // stray line noise cannot move the command
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      quad_d_reg <= 2'b00;
      quad_cnt_reg <= 32'h0;
    end
    else
    begin
      quad_d_reg <= {qa_s, qb_s};
      if (src_quad)
      begin
        // a leading b counts up, b leading a counts down
        case (quad_step(quad_d_reg, {qa_s, qb_s}))
          2'b01: quad_cnt_reg <= quad_cnt_reg + 32'h1;
          2'b11: quad_cnt_reg <= quad_cnt_reg - 32'h1;
          default: ;
        endcase
      end
    end
  end
  // ==========================================
  // position command; scaling costs a multiply and divide per cycle
  // the divide truncates toward zero, so a ratio below one drops
  // fractional counts; exact ratios need a denominator that divides
  // the scaled count
  wire signed [47:0] quad_scaled = $signed(quad_cnt_reg) * $signed({1'b0, gear_num_reg});
  wire signed [47:0] quad_div = quad_scaled / $signed({32'h0, gear_den_reg});
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      position_command <= 32'h0;
    else if (pos_mode && src_quad)
      position_command <= quad_div[31:0];
    else if (pos_mode)
      position_command <= step_cnt_reg;
  end
  // ==========================================
  // encoder emulation: selected resolution
  // the switch is read every cycle; turning it while running makes
  // the target jump to the new scale; the emulated count walks to it one paced step at a time
  reg [15:0] ppr_sel;
  always @*
  begin
    case (resolution_rotary_switch)
      4'h0: ppr_sel = user_ppr(user_ppr_reg);
      4'h1: ppr_sel = 16'd512;
      4'h2: ppr_sel = 16'd1000;
      4'h3: ppr_sel = 16'd1024;
      4'h4: ppr_sel = 16'd2000;
      4'h5: ppr_sel = 16'd2048;
      4'h6: ppr_sel = 16'd4096;
      4'h7: ppr_sel = 16'd5000;
      4'h8: ppr_sel = 16'd8192;
      default: ppr_sel = 16'd10000;
    endcase
  end
  // target quarter-line count from feedback: pos * ppr * 4 / 2^20
  // scale by four because each line gives four quadrature counts
  wire [37:0] tgt_full = {18'h0, fb_position} * {20'h0, ppr_sel, 2'b00};
  wire [17:0] tgt_cnt = tgt_full[37:20];
  // ==========================================
  // emulation tracking, one quarter step per paced slot
  // while emulation is off the count is parked on the target, so
  // switching on does not replay the whole way from zero
  // one step per paced slot bounds the line rate however fast the
  // shaft turns; a fast shaft then lags and catches up later
  localparam [31:0] QTR_CYC_FULL = `SCIO_QTR_CYC;
  localparam [8:0] QTR_CYC = QTR_CYC_FULL[8:0];
  reg [17:0] emu_cnt_reg;
  reg [8:0] pace_reg;
  wire emu_on = !src_quad && hires_fb_present;
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      emu_cnt_reg <= 18'h0;
      pace_reg <= 9'h0;
      chan_a_out <= 1'b0;
      chan_b_out <= 1'b0;
      chan_ab_oe_n <= 1'b1;
    end
    else
    begin
      chan_ab_oe_n <= src_quad; // outputs by default
      if (!emu_on)
      begin
        emu_cnt_reg <= tgt_cnt;
        pace_reg <= 9'h0;
      end
      // pacing keeps the line rate at the recommended cap
      else if (pace_reg != 9'h0)
        pace_reg <= pace_reg - 9'h1;
      else if (emu_cnt_reg != tgt_cnt)
      begin
        // forward and back chosen by shortest way round
        emu_cnt_reg <= ((tgt_cnt - emu_cnt_reg) < 18'h20000) ? emu_cnt_reg + 18'h1 : emu_cnt_reg - 18'h1;
        pace_reg <= QTR_CYC - 9'h1;
      end
      // gray sequence on the two low bits
      chan_a_out <= emu_on & (emu_cnt_reg[1] ^ 1'b0);
      chan_b_out <= emu_on & (emu_cnt_reg[1] ^ emu_cnt_reg[0]);
    end
  end
  // ==========================================
  // marker: high for the first line of each revolution
  // the marker follows the emulated count, not the raw feedback,
  // so it always lines up with the a/b edges around zero
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      marker_channel <= 1'b0;
      marker_oe_n <= 1'b1;
    end
    else
    begin
      marker_oe_n <= ~(emu_on & serial_fb_in_use);
      marker_channel <= emu_on & serial_fb_in_use & (emu_cnt_reg[17:2] == 16'h0);
    end
  end
endmodule // scio_top
`default_nettype wire

// ---- core/scio_map.vh ----
// constants for the servo command i/o block
// assumes a 250 mhz core clock and plain verilog-2005 tools
`ifndef SCIO_MAP_VH
`define SCIO_MAP_VH
// ==========================================
// register offsets (word index = byte address)
`define SCIO_ADDR_W 4
`define SCIO_REG_CTRL 4'h0
`define SCIO_REG_STAT 4'h1
`define SCIO_REG_USER_PPR 4'h2
`define SCIO_REG_GEAR_NUM 4'h3
`define SCIO_REG_GEAR_DEN 4'h4
`define SCIO_REG_POS_CMD 4'h5
`define SCIO_REG_QUAD_CNT 4'h6
// ==========================================
// control fields
`define SCIO_CTRL_POS_MODE 0
`define SCIO_CTRL_SRC_QUAD 1
`define SCIO_CTRL_RESET 32'h0000_0000
// ==========================================
// reset values
`define SCIO_USER_PPR_RESET 4'h9
`define SCIO_GEAR_RESET 16'h0001
// ==========================================
// timing
`define SCIO_CLK_MHZ 250
`define SCIO_LINE_MAX_KHZ 2500
`define SCIO_LINE_REC_KHZ 1250
// quarter line period in cycles at the recommended rate, rounded up
`define SCIO_QTR_CYC ((`SCIO_CLK_MHZ * 1000 + 4 * `SCIO_LINE_REC_KHZ - 1) / (4 * `SCIO_LINE_REC_KHZ))
`define SCIO_DIR_SETUP_US 100
`define SCIO_FB_BITS 20
`endif

// ---- core/scio_sync.v ----
// three-stage synchroniser with agreement filter for pin inputs
// assumes asynchronous inputs and a single clock
`timescale 1ns/1ps
`default_nettype none
module scio_sync
(
  // clock and reset
  input wire clk,
  input wire arst_n,
  // pin in, filtered level out
  input wire din,
  output reg dout
);
  // ==========================================
  // stages
  reg s1_reg; // metastable stage, read only by s2
  reg s2_reg;
  reg s3_reg;
  // shift and filter; a change counts when stages two and three agree
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        dout <= s3_reg;
    end
  end
endmodule // scio_sync
`default_nettype wire

// ---- verification/scio_top_sva.sv ----
// port checker for the servo command i/o block
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checker module
module scio_top_sva
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register read side
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // drive state
  input wire logic powered,
  input wire logic faulted,
  input wire logic enabled,
  input wire logic hires_fb_present,
  input wire logic serial_fb_in_use,
  // observed pins
  input wire logic chan_a_out,
  input wire logic chan_b_out,
  input wire logic marker_channel,
  input wire logic fault_status_output,
  input wire logic run_status_output
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // status follows drive state one cycle on; skip the edge right after reset
  a_fault_follows_state: assert property ($past(arst_n) |-> fault_status_output == $past(powered && !faulted))
    else $error("fault status wrong");
  a_run_follows_state: assert property ($past(arst_n) |-> run_status_output == $past(powered && !faulted && enabled))
    else $error("run status wrong");
  a_run_needs_fault: assert property (run_status_output |-> fault_status_output)
    else $error("run on without fault output");
  // read data only in the cycle after a read
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_marker_needs_serial: assert property (!serial_fb_in_use [*3] |-> !marker_channel)
    else $error("marker without serial feedback");
  a_ab_quiet_coarse: assert property (!hires_fb_present [*3] |-> $stable(chan_a_out) && $stable(chan_b_out))
    else $error("emulated outputs move without feedback");
  a_ab_single_edge: assert property (!($changed(chan_a_out) && $changed(chan_b_out)))
    else $error("a and b moved together");
  // cycles since the last emulated edge, saturating
  int gap_cnt = 0;
  always @(posedge clk)
  begin
    if (!arst_n || $changed(chan_a_out) || $changed(chan_b_out))
      gap_cnt <= 0;
    else if (gap_cnt < 1000)
      gap_cnt <= gap_cnt + 1;
  end
  // 2.5 mhz lines give edges 100 ns apart, 25 cycles
  a_ab_edge_spacing: assert property ($changed(chan_a_out) || $changed(chan_b_out) |-> gap_cnt >= 24)
    else $error("emulated edges too close");
  // main scenarios
  cover property ($rose(marker_channel));
  cover property ($changed(chan_a_out));
  cover property ($fell(run_status_output));
endmodule // scio_top_sva
bind scio_top scio_top_sva i_scio_top_sva (.clk, .arst_n, .reg_rd, .reg_rdata, .powered, .faulted, .enabled,
  .hires_fb_present, .serial_fb_in_use, .chan_a_out, .chan_b_out, .marker_channel, .fault_status_output,
  .run_status_output);
`default_nettype wire

// ---- verification/scio_ctrl_model.sv ----
// motion controller model driving step, direction and quadrature pins
// assumes the bench clock; pins change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// controller model
module scio_ctrl_model
#(
  parameter int SETUP_CYC = 25000 // 100 us direction setup at 4 ns
)
(
  // clock
  input wire logic clk,
  // command pins, high = current flowing
  output logic step_pulse_input,
  output logic direction_input_pin,
  output logic chan_a_in,
  output logic chan_b_in
);
  localparam int HI_CYC = 64; // 256 ns, above the minimum width
  localparam int LO_CYC = 104; // 672 ns period keeps under 1.5 mhz
  localparam int QEDGE_CYC = 100; // 2.5 mhz count rate, 625 khz line
  logic [1:0] ph = 2'h0; // quadrature phase
  int dir_age = 0; // cycles the direction level has stood
  logic dir_q = 1'b0;
  // age of the direction level, saturating at the setup time
  always @(posedge clk)
  begin
    dir_q <= direction_input_pin;
    if (dir_q !== direction_input_pin)
      dir_age <= 0;
    else if (dir_age < SETUP_CYC)
      dir_age <= dir_age + 1;
  end
  // idle pins: no current anywhere
  initial
  begin
    step_pulse_input = 1'b0;
    direction_input_pin = 1'b0;
    chan_a_in = 1'b0;
    chan_b_in = 1'b0;
  end
  // n whole step pulses after the direction setup
  task steps(input int n, input logic dir);
    @(posedge clk);
    direction_input_pin <= dir;
    repeat (2) @(posedge clk);
    while (dir_age < SETUP_CYC) @(posedge clk);
    repeat (n)
    begin
      step_pulse_input <= 1'b1;
      repeat (HI_CYC) @(posedge clk);
      step_pulse_input <= 1'b0;
      repeat (LO_CYC) @(posedge clk);
    end
  endtask
  // leading edge only; the next steps call ends the pulse
  task rise;
    @(posedge clk);
    step_pulse_input <= 1'b1;
    repeat (HI_CYC) @(posedge clk);
  endtask
  // n quadrature edges, a leads b when fwd
  task quad(input int n, input logic fwd);
    repeat (n)
    begin
      repeat (QEDGE_CYC) @(posedge clk);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      chan_a_in <= ph[1] ^ ph[0];
      chan_b_in <= ph[1];
    end
  endtask
endmodule // scio_ctrl_model
`default_nettype wire

// ---- verification/scio_top_tb.sv ----
// self-checking bench for the servo command i/o block
// assumes the controller model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
`include "scio_map.vh"
module scio_top_tb;
  localparam int QTR = (1 << 20) / (4 * 1024); // feedback units per quarter at 1024 lines
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic powered = 1'b1;
  logic faulted = 1'b0;
  logic enabled = 1'b1;
  logic hires_fb_present = 1'b0;
  logic serial_fb_in_use = 1'b0;
  logic [19:0] fb_position = 20'h0;
  logic [3:0] resolution_rotary_switch = 4'h3; // 1024 lines
  wire logic [31:0] reg_rdata, position_command;
  wire logic step_pulse_input, direction_input_pin, chan_a_in, chan_b_in, chan_a_out, chan_b_out;
  wire logic chan_ab_oe_n, marker_channel, marker_oe_n, fault_status_output, run_status_output;
  int bad_count = 0;
  int total_checks = 0;
  int edges = 0; // emulated a/b edges seen
  int e0;
  logic a_q, b_q;
  always #2 clk = ~clk;
  scio_top i_scio_top (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .powered, .faulted,
    .enabled, .hires_fb_present, .serial_fb_in_use, .fb_position, .resolution_rotary_switch, .step_pulse_input,
    .direction_input_pin, .chan_a_in, .chan_b_in, .chan_a_out, .chan_b_out, .chan_ab_oe_n, .marker_channel,
    .marker_oe_n, .fault_status_output, .run_status_output, .position_command);
  // full direction setup; the first steps call and each direction change pay for it
  scio_ctrl_model i_scio_ctrl_model (.clk, .step_pulse_input, .direction_input_pin,
    .chan_a_in, .chan_b_in);
  // edge counter on the emulated outputs
  always @(posedge clk)
  begin
    a_q <= chan_a_out;
    b_q <= chan_b_out;
    if (arst_n && (a_q !== chan_a_out || b_q !== chan_b_out))
      edges <= edges + 1;
  end
  // ==========================================
  // helpers
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rdchk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog, run needs about 210 us, mostly two direction setups
  initial
  begin
    #300000;
    bad_count++;
    results;
  end
  // ==========================================
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    cyc(2);
    chk(chan_ab_oe_n, 1'b0);
    rdchk(`SCIO_REG_USER_PPR, 32'h9);
    rdchk(`SCIO_REG_GEAR_NUM, 32'h1);
    rdchk(4'hf, 32'h0);
    // every powered/faulted/enabled combination
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      {powered, faulted, enabled} <= i[2:0];
      cyc(2);
      chk(fault_status_output, i[2] & ~i[1]);
      chk(run_status_output, i[2] & ~i[1] & i[0]);
    end
    // step and direction
    wr(`SCIO_REG_CTRL, 32'h1);
    i_scio_ctrl_model.steps(3, 1'b0);
    cyc(1);
    chk(position_command, 32'h3);
    i_scio_ctrl_model.steps(2, 1'b1);
    rdchk(`SCIO_REG_POS_CMD, 32'h1);
    i_scio_ctrl_model.rise();
    cyc(1);
    chk(position_command, 32'h1);
    i_scio_ctrl_model.steps(1, 1'b1);
    cyc(1);
    chk(position_command, 32'h0);
    // quadrature input, ratio 3/2, zero divisor refused
    wr(`SCIO_REG_GEAR_NUM, 32'h3);
    wr(`SCIO_REG_GEAR_DEN, 32'h0);
    rdchk(`SCIO_REG_GEAR_DEN, 32'h1);
    wr(`SCIO_REG_GEAR_DEN, 32'h2);
    wr(`SCIO_REG_CTRL, 32'h3);
    cyc(2);
    chk(chan_ab_oe_n, 1'b1);
    i_scio_ctrl_model.quad(4, 1'b1);
    cyc(10);
    chk(position_command, 32'h6);
    i_scio_ctrl_model.quad(2, 1'b0);
    cyc(10);
    rdchk(`SCIO_REG_QUAD_CNT, 32'h2);
    chk(position_command, 32'h3);
    // encoder emulation and marker
    wr(`SCIO_REG_CTRL, 32'h0);
    @(posedge clk);
    hires_fb_present <= 1'b1;
    serial_fb_in_use <= 1'b1;
    cyc(10);
    chk(chan_ab_oe_n, 1'b0);
    chk(marker_channel, 1'b1);
    chk(marker_oe_n, 1'b0);
    e0 = edges;
    @(posedge clk);
    fb_position <= 20'(9 * QTR);
    cyc(9 * 50 + 100);
    chk(edges - e0, 32'h9);
    chk({chan_a_out, chan_b_out}, 2'h1);
    chk(marker_channel, 1'b0);
    @(posedge clk);
    serial_fb_in_use <= 1'b0;
    hires_fb_present <= 1'b0;
    cyc(10);
    chk({chan_a_out, chan_b_out}, 2'h0);
    chk(marker_oe_n, 1'b1);
    results;
  end
endmodule // scio_top_tb
`default_nettype wire
